// ==== core/decode_timing_pkg.sv ====
// shared constants and types for the integer decode and timing block
package decode_timing_pkg;

  // ==========================================================================
  // flag action codes and instruction classes
  typedef enum logic [2:0] {FA_UNCH, FA_MOD, FA_ZERO, FA_ONE, FA_UNDEF}
    flag_act_t;
  typedef enum logic [3:0] {CL_NONE, CL_DIV, CL_SIGNED_DIVIDE, CL_ENTER, CL_IMUL2,
    CL_IN, CL_JCC, CL_FLAGS_TO_UPPER_ACC_BYTE, CL_LAR, CL_MOVSEG, CL_POPSEG, CL_LEA, CL_INC,
    CL_INVOP, CL_MOVIMM} instr_class_t;
  typedef enum {ST_IDLE, ST_EXEC} exec_state_t;

  // ==========================================================================
  // opcode bytes and fields
  localparam logic [7:0] OP_ESC = 8'h0F;
  localparam logic [7:0] OP_ENTER = 8'hC8;
  localparam logic [7:0] OP_FLAGS_TO_UPPER_ACC_BYTE = 8'h9F;
  localparam logic [7:0] OP_LEA = 8'h8D;
  localparam logic [7:0] OP_MOVSEG = 8'h8E;
  localparam logic [7:0] OP_GRP3 = 8'hF6;
  localparam logic [7:0] OP_GRP4 = 8'hFE;
  localparam logic [7:0] OP_IN_FIX = 8'hE4;
  localparam logic [7:0] OP_IN_VAR = 8'hEC;
  localparam logic [7:0] OP_INC_SHORT = 8'h40;
  localparam logic [7:0] OP_POP_ES = 8'h07;
  localparam logic [7:0] OP_POP_SS = 8'h17;
  localparam logic [7:0] OP_POP_DS = 8'h1F;
  localparam logic [7:0] OP2_POP_FS = 8'hA1;
  localparam logic [7:0] OP2_POP_GS = 8'hA9;
  localparam logic [7:0] OP2_SIGNED_MULTIPLY = 8'hAF;
  localparam logic [7:0] OP2_LAR = 8'h02;
  localparam logic [7:0] OP2_LSL = 8'h03;
  localparam logic [7:0] OP2_INVOP = 8'hFF;
  localparam logic [3:0] OP_JCC_HI = 4'h7;
  localparam logic [3:0] OP2_JCC_HI = 4'h8;
  localparam logic [3:0] OP_MOVIMM_HI = 4'hB;
  localparam logic [2:0] REG_INC = 3'h0;
  localparam logic [2:0] REG_DIV = 3'h6;
  localparam logic [2:0] REG_SIGNED_DIVIDE = 3'h7;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISPF = 2'h2;

  // ==========================================================================
  // core clock counts (register or cache hit)
  localparam logic [9:0] CYC_ONE = 10'h001;
  localparam logic [9:0] CYC_FLAGS_TO_UPPER_ACC_BYTE = 10'h002;
  localparam logic [9:0] CYC_SEG_PROT = 10'h003;
  localparam logic [9:0] CYC_SIGNED_MULTIPLY_W = 10'h004;
  localparam logic [9:0] CYC_SIGNED_MULTIPLY_D = 10'h00A;
  localparam logic [9:0] CYC_LARLSL = 10'h008;
  localparam logic [9:0] CYC_IN = 10'h00E;
  localparam logic [9:0] CYC_IN_PRIV = 10'h01C;
  localparam logic [9:0] CYC_DIV_BASE = 10'h00D;
  localparam logic [9:0] CYC_SIGNED_DIVIDE_BASE = 10'h010;
  localparam logic [9:0] CYC_SIGNED_DIVIDE_BASE_D = 10'h011;
  localparam logic [9:0] CYC_ENTER_L0 = 10'h00A;
  localparam logic [9:0] CYC_ENTER_L1 = 10'h00D;
  localparam logic [9:0] CYC_ENTER_STEP = 10'h003;
  localparam logic [9:0] CYC_OIO_PROT = 10'h008;
  localparam logic [6:0] SPAN_B = 7'h04;
  localparam logic [6:0] SPAN_W = 7'h0C;
  localparam logic [6:0] SPAN_D = 7'h1C;
  localparam logic [6:0] SPAN_OIO = 7'h75;

  // ==========================================================================
  // flag action vectors, order OF DF IF TF SF ZF AF PF CF
  localparam logic [26:0] FLAGS_NONE = {9{FA_UNCH}};
  localparam logic [26:0] FLAGS_DIV = {FA_UNCH, FA_UNCH, FA_UNCH, FA_UNCH,
    FA_MOD, FA_MOD, FA_UNDEF, FA_UNDEF, FA_UNCH};
  localparam logic [26:0] FLAGS_SIGNED_MULTIPLY = {FA_MOD, FA_UNCH, FA_UNCH, FA_UNCH,
    FA_MOD, FA_MOD, FA_UNDEF, FA_UNDEF, FA_MOD};
  localparam logic [26:0] FLAGS_INC = {FA_MOD, FA_UNCH, FA_UNCH, FA_UNCH,
    FA_MOD, FA_MOD, FA_MOD, FA_MOD, FA_UNCH};
  localparam logic [26:0] FLAGS_ZF = {FA_UNCH, FA_UNCH, FA_UNCH, FA_UNCH,
    FA_UNCH, FA_MOD, FA_UNCH, FA_UNCH, FA_UNCH};
  localparam logic [26:0] FLAGS_OIO = {FA_UNCH, FA_UNCH, FA_MOD, FA_ZERO,
    FA_UNCH, FA_UNCH, FA_UNCH, FA_UNCH, FA_UNCH};

  // ==========================================================================
  // field lengths in bytes and reset values
  localparam logic [2:0] LEN_0 = 3'h0;
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;
  localparam logic [9:0] CYC_RESET = 10'h000;

endpackage : decode_timing_pkg

// ==== core/instr_timing.sv ====
// decode and execution timing of a slice of the integer instruction set
`timescale 1ns/100ps

// Overview of operation
// - unsigned divide 13-17, 13-25, 13-41 clocks
// - signed divide 16-20/16-28/17-45; SF ZF modified
// - two-byte signed multiply: 4 word, 10 dword
// - port input 14 real; 14 or 28 protected
// - jumps: short and escape forms, 1 clock
// - flags to upper accumulator byte: 2 clocks
// - rights and limit loads: protected only, 8, ZF
// - segment register move: 1 real, 1/3 protected
// - segment pop: 1 real, 3 protected
// - effective address load: 1 clock, no flags
// - increment both forms 1 clock, carry kept
// - immediates of 1, 3 or operand-size bytes
// - displacements of 1 or full size
// - short immediate register move: 1 clock
// - counts are core clock cycles
// - flag actions use five codes
// - counts assume prefetched, hit, no exception
module instr_timing (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // instruction request
  input wire logic START,
  input wire logic [7:0] OP0,
  input wire logic [7:0] OP1,
  input wire logic [7:0] MODRM,
  // mode and operand conditions
  input wire logic PROT_MODE,
  input wire logic OPSIZE32,
  input wire logic CPL_LE_IOPL,
  input wire logic SEG_SLOW,
  input wire logic SEL_OK,
  input wire logic [7:0] LEVEL,
  input wire logic [6:0] VAR_EXTRA,
  // results
  output logic BUSY,
  output logic DONE,
  output logic ILLEGAL,
  output logic [9:0] CYCLES,
  output logic [26:0] FLAG_ACT,
  output logic ZF_VALUE,
  output logic [2:0] IMM_LEN,
  output logic [2:0] DISP_LEN
);
  import decode_timing_pkg::*;

  // ==========================================================================
  // decode helpers
  // full field size follows the operand size
  function automatic logic [2:0] full_len(input logic sz32);
    full_len = sz32 ? LEN_4 : LEN_2;
  endfunction : full_len

  // variable part clipped to its span, so counts stay inside the range
  function automatic logic [9:0] ranged(input logic [9:0] base,
                                        input logic [6:0] span,
                                        input logic [6:0] extra);
    ranged = base + {3'h0, (extra > span) ? span : extra};
  endfunction : ranged

  // displacement carried by a modrm byte
  function automatic logic [2:0] modrm_disp(input logic [7:0] m,
                                            input logic sz32);
    if (m[7:6] == MOD_DISP8) begin
      modrm_disp = LEN_1;
    end else if (m[7:6] == MOD_DISPF) begin
      modrm_disp = full_len(sz32);
    end else begin
      modrm_disp = LEN_0;
    end
  endfunction : modrm_disp

  // ==========================================================================
  // classify the opcode bytes
  instr_class_t cls_c;
  logic esc;
  logic take;
  exec_state_t state_q, state_d;

  always_comb begin
    esc = (OP0 == OP_ESC);
    cls_c = CL_NONE;
    if (esc) begin
      if (OP1 == OP2_SIGNED_MULTIPLY) cls_c = CL_IMUL2;
      else if (OP1 == OP2_LAR || OP1 == OP2_LSL) cls_c = CL_LAR;
      else if (OP1 == OP2_INVOP) cls_c = CL_INVOP;
      else if (OP1[7:4] == OP2_JCC_HI) cls_c = CL_JCC;
      else if (OP1 == OP2_POP_FS || OP1 == OP2_POP_GS) cls_c = CL_POPSEG;
    end else if (OP0[7:1] == OP_GRP3[7:1] && MODRM[5:3] == REG_DIV) begin
      cls_c = CL_DIV;
    end else if (OP0[7:1] == OP_GRP3[7:1] && MODRM[5:3] == REG_SIGNED_DIVIDE) begin
      cls_c = CL_SIGNED_DIVIDE;
    end else if ((OP0[7:1] == OP_GRP4[7:1] && MODRM[5:3] == REG_INC) ||
                 OP0[7:3] == OP_INC_SHORT[7:3]) begin
      cls_c = CL_INC;
    end else if (OP0[7:1] == OP_IN_FIX[7:1] ||
                 OP0[7:1] == OP_IN_VAR[7:1]) begin
      cls_c = CL_IN;
    end else if (OP0[7:4] == OP_JCC_HI) begin
      cls_c = CL_JCC;
    end else if (OP0[7:4] == OP_MOVIMM_HI) begin
      cls_c = CL_MOVIMM;
    end else if (OP0 == OP_ENTER) begin
      cls_c = CL_ENTER;
    end else if (OP0 == OP_FLAGS_TO_UPPER_ACC_BYTE) begin
      cls_c = CL_FLAGS_TO_UPPER_ACC_BYTE;
    end else if (OP0 == OP_LEA) begin
      cls_c = CL_LEA;
    end else if (OP0 == OP_MOVSEG) begin
      cls_c = CL_MOVSEG;
    end else if (OP0 == OP_POP_ES || OP0 == OP_POP_SS ||
                 OP0 == OP_POP_DS) begin
      cls_c = CL_POPSEG;
    end
  end

  assign take = START && (state_q == ST_IDLE);

  // ==========================================================================
  // clocks, flags and field lengths of the classified instruction
  // counts are in core clocks of a prefetched, hitting, exception-free
  // instruction; misses and faults are added by the pipeline, not here
  logic [9:0] cyc_c;
  logic [26:0] flags_c;
  logic [2:0] imm_c, disp_c;
  logic bad_c;
  logic byte_op;

  always_comb begin
    byte_op = ~OP0[0];
    cyc_c = CYC_ONE;
    flags_c = FLAGS_NONE;
    imm_c = LEN_0;
    disp_c = modrm_disp(MODRM, OPSIZE32);
    bad_c = 1'b0;
    unique case (cls_c)
      CL_DIV: begin
        flags_c = FLAGS_DIV;
        if (byte_op) cyc_c = ranged(CYC_DIV_BASE, SPAN_B, VAR_EXTRA);
        else if (!OPSIZE32) cyc_c = ranged(CYC_DIV_BASE, SPAN_W, VAR_EXTRA);
        else cyc_c = ranged(CYC_DIV_BASE, SPAN_D, VAR_EXTRA);
      end
      CL_SIGNED_DIVIDE: begin
        flags_c = FLAGS_DIV;
        if (byte_op) cyc_c = ranged(CYC_SIGNED_DIVIDE_BASE, SPAN_B, VAR_EXTRA);
        else if (!OPSIZE32) cyc_c = ranged(CYC_SIGNED_DIVIDE_BASE, SPAN_W, VAR_EXTRA);
        else cyc_c = ranged(CYC_SIGNED_DIVIDE_BASE_D, SPAN_D, VAR_EXTRA);
      end
      CL_ENTER: begin
        imm_c = LEN_3;
        disp_c = LEN_0;
        if (LEVEL == 8'h00) cyc_c = CYC_ENTER_L0;
        else if (LEVEL == 8'h01) cyc_c = CYC_ENTER_L1;
        else cyc_c = CYC_ENTER_L0 + 10'(LEVEL) * CYC_ENTER_STEP;
      end
      CL_IMUL2: begin
        flags_c = FLAGS_SIGNED_MULTIPLY;
        cyc_c = OPSIZE32 ? CYC_SIGNED_MULTIPLY_D : CYC_SIGNED_MULTIPLY_W;
      end
      CL_IN: begin
        disp_c = LEN_0;
        imm_c = OP0[3] ? LEN_0 : LEN_1;
        cyc_c = (PROT_MODE && !CPL_LE_IOPL) ? CYC_IN_PRIV : CYC_IN;
      end
      CL_JCC: begin
        disp_c = esc ? full_len(OPSIZE32) : LEN_1;
      end
      CL_FLAGS_TO_UPPER_ACC_BYTE: begin
        disp_c = LEN_0;
        cyc_c = CYC_FLAGS_TO_UPPER_ACC_BYTE;
      end
      CL_LAR: begin
        bad_c = !PROT_MODE;
        flags_c = FLAGS_ZF;
        cyc_c = CYC_LARLSL;
      end
      CL_MOVSEG: begin
        cyc_c = (PROT_MODE && SEG_SLOW) ? CYC_SEG_PROT : CYC_ONE;
      end
      CL_POPSEG: begin
        disp_c = LEN_0;
        cyc_c = PROT_MODE ? CYC_SEG_PROT : CYC_ONE;
      end
      CL_LEA: begin
        cyc_c = CYC_ONE;
      end
      CL_INC: begin
        flags_c = FLAGS_INC;
        if (!esc && OP0[7:3] == OP_INC_SHORT[7:3]) disp_c = LEN_0;
      end
      CL_INVOP: begin
        flags_c = FLAGS_OIO;
        disp_c = LEN_0;
        cyc_c = PROT_MODE ? ranged(CYC_OIO_PROT, SPAN_OIO, VAR_EXTRA)
                          : CYC_ONE;
      end
      CL_MOVIMM: begin
        disp_c = LEN_0;
        imm_c = OP0[3] ? full_len(OPSIZE32) : LEN_1;
      end
      default: begin
        bad_c = 1'b1; // opcode outside this slice
        disp_c = LEN_0;
      end
    endcase
  end

  // ==========================================================================
  // execution sequencer: busy for exactly the counted core clocks
  logic [9:0] cnt_q, cnt_d;
  logic busy_d, done_d, ill_d, zf_d;
  logic [9:0] cyc_d;
  logic [26:0] fa_d;
  logic [2:0] imm_d, disp_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    busy_d = BUSY;
    done_d = 1'b0;
    ill_d = 1'b0;
    zf_d = ZF_VALUE;
    cyc_d = CYCLES;
    fa_d = FLAG_ACT;
    imm_d = IMM_LEN;
    disp_d = DISP_LEN;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          imm_d = imm_c;
          disp_d = disp_c;
          if (bad_c) begin
            // refused at once, nothing runs, flags untouched
            done_d = 1'b1;
            ill_d = 1'b1;
            cyc_d = CYC_RESET;
            fa_d = FLAGS_NONE;
          end else begin
            state_d = ST_EXEC;
            busy_d = 1'b1;
            cnt_d = cyc_c;
            cyc_d = cyc_c;
            fa_d = flags_c;
            zf_d = (cls_c == CL_LAR) ? SEL_OK : ZF_VALUE;
          end
        end
      end
      ST_EXEC: begin
        cnt_d = cnt_q - CYC_ONE;
        if (cnt_q == CYC_ONE) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
    endcase
  end

  // registers only; outputs come straight from these flops
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      cnt_q <= CYC_RESET;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      ZF_VALUE <= 1'b0;
      CYCLES <= CYC_RESET;
      FLAG_ACT <= FLAGS_NONE;
      IMM_LEN <= LEN_0;
      DISP_LEN <= LEN_0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      BUSY <= busy_d;
      DONE <= done_d;
      ILLEGAL <= ill_d;
      ZF_VALUE <= zf_d;
      CYCLES <= cyc_d;
      FLAG_ACT <= fa_d;
      IMM_LEN <= imm_d;
      DISP_LEN <= disp_d;
    end
  end

  // ==========================================================================
  // checks
  logic [9:0] run_q;
  always_ff @(posedge CLK) begin
    if (!RSTN) run_q <= CYC_RESET;
    else run_q <= BUSY ? run_q + CYC_ONE : CYC_RESET;
  end

  sequence s_take(instr_class_t c);
    take && !bad_c && cls_c == c;
  endsequence

  AST_DIV_RANGE: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take(CL_DIV) |=> CYCLES >= 10'h00D && CYCLES <= 10'h029)
    else $error("unsigned divide count out of range");
  AST_SIGNED_DIVIDE_FLAGS: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take(CL_SIGNED_DIVIDE) && !OP0[0] |=> CYCLES >= 10'h010 &&
    CYCLES <= 10'h014 && FLAG_ACT == FLAGS_DIV)
    else $error("signed byte divide count or flags wrong");
  AST_ENTER_L1: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take(CL_ENTER) && LEVEL == 8'h01 |=> CYCLES == 10'h00D ##13 DONE)
    else $error("enter level one timing wrong");
  AST_SIGNED_MULTIPLY_D: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take(CL_IMUL2) && OPSIZE32 |=> CYCLES == 10'h00A ##10 DONE)
    else $error("dword multiply not ten clocks");
  AST_IN_PRIV: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take(CL_IN) && PROT_MODE && !CPL_LE_IOPL |=> CYCLES == 10'h01C)
    else $error("privileged input not 28 clocks");
  AST_JCC_ONE: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take(CL_JCC) |=> BUSY && FLAG_ACT == FLAGS_NONE ##1 !BUSY && DONE)
    else $error("jump not one clock");
  AST_FLAGS_TO_UPPER_ACC_BYTE: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take(CL_FLAGS_TO_UPPER_ACC_BYTE) |=> CYCLES == 10'h002 && FLAG_ACT == FLAGS_NONE)
    else $error("flag load timing wrong");
  AST_LAR_REAL: assert property (@(posedge CLK) disable iff (!RSTN)
    take && cls_c == CL_LAR && !PROT_MODE |=> ILLEGAL && DONE && !BUSY)
    else $error("rights load accepted in real mode");
  AST_POPSEG: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take(CL_POPSEG) && PROT_MODE |=> CYCLES == 10'h003)
    else $error("segment pop not three clocks");
  AST_INC_CF: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take(CL_INC) |=> FLAG_ACT[2:0] == FA_UNCH && CYCLES == 10'h001)
    else $error("increment touches carry or slow");
  AST_RUN_LEN: assert property (@(posedge CLK) disable iff (!RSTN)
    $fell(BUSY) |-> $past(run_q) + 10'h001 == CYCLES && DONE)
    else $error("busy length differs from count");

endmodule : instr_timing

// ==== verification/testbench.sv ====
// self-checking bench for the integer decode and timing block
`timescale 1ns/100ps
module testbench;
  import decode_timing_pkg::*;

  // ==========================================================================
  // expectation record, signals and stimulus pools
  typedef struct {
    logic [9:0] cyc;
    logic [26:0] flg;
    logic ill, ldz, zf, chkzf;
    logic [2:0] imm, disp;
  } exp_t;
  logic CLK, RSTN, START, PROT_MODE, OPSIZE32, CPL_LE_IOPL, SEG_SLOW, SEL_OK;
  logic [7:0] OP0, OP1, MODRM, LEVEL;
  logic [6:0] VAR_EXTRA;
  logic BUSY, DONE, ILLEGAL, ZF_VALUE;
  logic [9:0] CYCLES;
  logic [26:0] FLAG_ACT;
  logic [2:0] IMM_LEN, DISP_LEN;
  int n_mismatch, n_tests, busy_n;
  exp_t expq[$];
  exp_t mon_e;
  logic zf_exp, zf_known;
  logic [6:0] xv[$] = '{7'h00, 7'h04, 7'h05, 7'h0C, 7'h0D, 7'h1C, 7'h1D,
    7'h7F};
  logic [7:0] pool[$] = '{8'hF6, 8'hF7, 8'hFE, 8'hFF, 8'hC8, 8'h0F, 8'hE4,
    8'hEC, 8'h70, 8'h9F, 8'h8E, 8'h07, 8'h17, 8'h1F, 8'h8D, 8'h40, 8'hB0,
    8'h90};
  logic [7:0] pool2[$] = '{8'hAF, 8'h02, 8'h03, 8'h80, 8'hA1, 8'hA9, 8'hFF,
    8'h00};
  // rows: op0 op1 | modrm level | extra mode{prot,sz32,cpl,slow,sel}
  logic [47:0] dir[$] = '{
    48'hC800_0000_0000, 48'hC800_0001_0000, 48'hC800_0002_0010,
    48'hC800_00FF_0000, 48'h0FAF_4500_0000, 48'h0FAF_8500_0018,
    48'hE400_0000_0000, 48'hEC00_0000_0010, 48'hEC00_0000_0014,
    48'hE400_0000_0014, 48'h7500_0000_0000, 48'h0F85_0000_0000,
    48'h0F85_0000_0008, 48'h9F00_0000_0010, 48'h0F02_C000_0001,
    48'h0F02_C000_0011, 48'h0F03_4000_0010, 48'h9F00_0000_0011,
    48'h8ED8_0000_0002, 48'h8ED8_0000_0012, 48'h8E98_0000_0010,
    48'h0700_0000_0000, 48'h1700_0000_0010, 48'h1F00_0000_0010,
    48'h0FA1_0000_0000, 48'h0FA1_0000_0010, 48'h0FA9_0000_0010,
    48'h8D04_0000_0000, 48'h8D84_0000_0008, 48'hFEC0_0000_0000,
    48'hFF40_0000_0008, 48'h4000_0000_0000, 48'h4700_0000_0010,
    48'h0FFF_0000_7F00, 48'h0FFF_0000_0010, 48'h0FFF_0000_7510,
    48'h0FFF_0000_7F10, 48'hB000_0000_0000, 48'hB800_0000_0000,
    48'hBF00_0000_0008, 48'h9000_0000_0000, 48'hF6C0_0000_0000,
    48'h0F00_0000_0010};

  // ==========================================================================
  // clock and design under test
  always #50 CLK = ~CLK;

  instr_timing u_instr_timing (
    .CLK(CLK), .RSTN(RSTN), .START(START), .OP0(OP0), .OP1(OP1),
    .MODRM(MODRM), .PROT_MODE(PROT_MODE), .OPSIZE32(OPSIZE32),
    .CPL_LE_IOPL(CPL_LE_IOPL), .SEG_SLOW(SEG_SLOW), .SEL_OK(SEL_OK),
    .LEVEL(LEVEL), .VAR_EXTRA(VAR_EXTRA), .BUSY(BUSY), .DONE(DONE),
    .ILLEGAL(ILLEGAL), .CYCLES(CYCLES), .FLAG_ACT(FLAG_ACT),
    .ZF_VALUE(ZF_VALUE), .IMM_LEN(IMM_LEN), .DISP_LEN(DISP_LEN));

  // ==========================================================================
  // reference model of counts, flag actions and field lengths
  function automatic exp_t model(input logic [7:0] o0, o1, m, lv,
      input logic [6:0] x, input logic [4:0] md);
    exp_t e;
    logic p, s;
    logic [2:0] dl, fl;
    int lim, xs;
    e = '{default: '0};
    e.flg = FLAGS_NONE;
    e.cyc = CYC_ONE;
    p = md[4];
    s = md[3];
    fl = s ? LEN_4 : LEN_2;
    dl = (m[7:6] == MOD_DISP8) ? LEN_1 : (m[7:6] == MOD_DISPF) ? fl : LEN_0;
    lim = o0[0] ? (s ? 28 : 12) : 4;
    xs = (x < lim) ? x : lim; // operand picks a point inside the range
    case (o0)
      8'hF6, 8'hF7: begin
        e.disp = dl;
        e.flg = FLAGS_DIV;
        if (m[5:3] == REG_DIV) e.cyc = 10'(13 + xs);
        else if (m[5:3] == REG_SIGNED_DIVIDE)
          e.cyc = 10'((o0[0] && s ? 17 : 16) + xs);
        else e.ill = 1'b1;
      end
      8'hFE, 8'hFF: begin
        e.disp = dl;
        e.flg = FLAGS_INC;
        e.ill = (m[5:3] != REG_INC);
      end
      8'hC8: begin
        e.imm = LEN_3;
        e.cyc = 10'(lv == 0 ? 10 : lv == 1 ? 13 : 10 + 3 * lv);
      end
      8'h0F: case (o1)
        8'hAF: begin
          e.cyc = 10'(s ? 10 : 4);
          e.flg = FLAGS_SIGNED_MULTIPLY;
          e.disp = dl;
        end
        8'h02, 8'h03: begin
          e.ill = !p;
          e.ldz = p;
          e.cyc = 10'(8);
          e.flg = FLAGS_ZF;
          e.disp = dl;
        end
        8'hA1, 8'hA9: e.cyc = 10'(p ? 3 : 1);
        8'hFF: begin
          e.cyc = 10'(p ? 8 + (x < 117 ? x : 117) : 1);
          e.flg = FLAGS_OIO;
        end
        default: if (o1[7:4] == 4'h8) e.disp = fl;
          else e.ill = 1'b1;
      endcase
      8'hE4, 8'hEC: begin
        e.cyc = 10'(p && !md[2] ? 28 : 14);
        e.imm = o0[3] ? LEN_0 : LEN_1;
      end
      8'h9F: e.cyc = 10'(2);
      8'h8E: begin
        e.cyc = 10'(p && md[1] ? 3 : 1);
        e.disp = dl;
      end
      8'h07, 8'h17, 8'h1F: e.cyc = 10'(p ? 3 : 1);
      8'h8D: e.disp = dl;
      default:
        if (o0[7:4] == 4'h7) e.disp = LEN_1;
        else if (o0[7:3] == 5'h08) e.flg = FLAGS_INC;
        else if (o0[7:4] == 4'hB) e.imm = o0[3] ? fl : LEN_1;
        else e.ill = 1'b1;
    endcase
    if (e.ill) e.cyc = '0;
    return e;
  endfunction : model

  // ==========================================================================
  // comparison, closing and driver tasks
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // one instruction; returns at the negedge that shows its completion
  task automatic run(input logic [7:0] o0, o1, m, lv, input logic [6:0] x,
      input logic [4:0] md, input logic poke);
    exp_t e;
    int k;
    e = model(o0, o1, m, lv, x, md);
    if (e.ldz) begin
      zf_exp = md[0];
      zf_known = 1'b1;
    end
    if (e.ill) zf_known = 1'b0; // conservative: refusal may disturb it
    e.zf = zf_exp;
    e.chkzf = zf_known;
    expq.push_back(e);
    {OP0, OP1, MODRM, LEVEL, VAR_EXTRA} = {o0, o1, m, lv, x};
    {PROT_MODE, OPSIZE32, CPL_LE_IOPL, SEG_SLOW, SEL_OK} = md;
    START = 1'b1;
    @(negedge CLK);
    // a refused one ends now: START stays up for the next call to reuse
    if (!e.ill) begin
      // scramble inputs after the take; results must use the latched copy
      {OP0, SEL_OK} = {8'h9F, ~md[0]};
      START = poke && e.cyc > 3; // a request while busy must be ignored
    end
    k = 0;
    while (DONE !== 1'b1 && k < 900) begin
      @(negedge CLK);
      if (START === 1'b1) START = 1'b0;
      k++;
    end
    if (k >= 900) check("DONE", 32'(DONE), 32'h1);
  endtask : run

  // ==========================================================================
  // monitor: pairs each completion with the oldest expectation
  always @(negedge CLK) begin
    if (BUSY === 1'b1) busy_n++;
    if (RSTN === 1'b1 && DONE === 1'b1) begin
      if (expq.size() == 0) check("DONE", 32'(DONE), 32'h0);
      else begin
        mon_e = expq.pop_front();
        check("ILLEGAL", 32'(ILLEGAL), 32'(mon_e.ill));
        check("CYCLES", 32'(CYCLES), 32'(mon_e.cyc));
        if (!mon_e.ill) begin
          check("BUSY", 32'(busy_n), 32'(mon_e.cyc));
          check("FLAG_ACT", 32'(FLAG_ACT), 32'(mon_e.flg));
          check("IMM_LEN", 32'(IMM_LEN), 32'(mon_e.imm));
          check("DISP_LEN", 32'(DISP_LEN), 32'(mon_e.disp));
        end
        if (mon_e.chkzf) check("ZF", 32'(ZF_VALUE), 32'(mon_e.zf));
      end
      busy_n = 0;
    end
  end

  // ==========================================================================
  // watchdog sized well above the expected run length
  initial begin
    #(100 * 60000);
    $display("MISMATCH watchdog expected done seen hang");
    n_mismatch++;
    finish_test();
  end

  // ==========================================================================
  // main sequence: reset, directed cases, then random traffic
  initial begin
    logic [7:0] o0, o1;
    CLK = 1'b0;
    RSTN = 1'b0;
    {START, PROT_MODE, OPSIZE32, CPL_LE_IOPL, SEG_SLOW, SEL_OK} = '0;
    {OP0, OP1, MODRM, LEVEL, VAR_EXTRA} = '0;
    zf_exp = 1'b0;
    zf_known = 1'b1;
    void'($urandom(4191));
    repeat (12) @(negedge CLK);
    RSTN = 1'b1;
    @(negedge CLK);
    check("CYCLES", 32'(CYCLES), 32'h0);
    check("FLAG_ACT", 32'(FLAG_ACT), 32'h0);
    check("STATUS", 32'({BUSY, DONE, ILLEGAL, ZF_VALUE}), 32'h0);
    // divide range ends and clipping, both modes and sizes, back to back
    foreach (xv[i]) for (int k = 0; k < 16; k++)
      run(k[0] ? 8'hF7 : 8'hF6, 8'h00, k[1] ? 8'hF8 : 8'h70, 8'h00, xv[i],
          {k[3], k[2], 3'h0}, 1'b1);
    foreach (dir[i])
      run(dir[i][47:40], dir[i][39:32], dir[i][31:24], dir[i][23:16],
          dir[i][14:8], dir[i][4:0], 1'b1);
    repeat (400) begin
      o0 = pool[$urandom % pool.size()];
      if (o0 == 8'h70 || o0 == 8'hB0) o0[3:0] = 4'($urandom);
      if (o0 == 8'h40) o0[2:0] = 3'($urandom);
      o1 = pool2[$urandom % pool2.size()];
      if (o1 == 8'h80) o1[3:0] = 4'($urandom);
      run(o0, o1, 8'($urandom), 8'($urandom), 7'($urandom), 5'($urandom),
          1'($urandom));
    end
    START = 1'b0; // a refused last request leaves it up
    repeat (4) @(negedge CLK);
    check("QUEUE", 32'(expq.size()), 32'h0);
    finish_test();
  end
endmodule : testbench
